// file: hw/scsl_consts.svh
// Constants for the service-control register and serial clock selector
// Overview of operation
// - Load strobe rising edge loads all held bits
// - Ten bits held; bits 2, 4, 5 and 12-14 unassigned
// - Bits 8-11 feed receiver configuration
// - Normal mode routes modem data and clock
// - Clock loss hold substitutes internal clock
// - Half duplex transmit suppresses receive clock
// - Modem transmit clock becomes transmit clock
// - Oscillator near 28 KHz halved to 14
// - Oscillator free running without reset
// - Crystal divided by 16 or 2
// - Crystal counter never loaded or cleared
// - Loopback wraps transmit data to receiver
// - Loopback drives both clocks from oscillator
// - Loopback holds modem data line fixed
// - Loopback passes data while bit 7 clear
// - Bit 7 sets only while transmitter idle
// - Bit 7 toggles show on receiver input
// - Step mode clocks from stored strobe bit
// - Set strobes transmit, clear strobes receive
`ifndef SCSL_CONSTS_SVH
`define SCSL_CONSTS_SVH
`define SVC_STROBE_BIT 0
`define SVC_STEP_BIT 1
`define SVC_LOOP_BIT 3
`define SVC_UNUSED6_BIT 6
`define SVC_SEND_BIT 7
`define SVC_CFG_LSB 8
`define SVC_CFG_MSB 11
`define SVC_UNUSED15_BIT 15
`define SVC_HELD_MASK 16'h8fcb
`define SVC_RESET 16'h0000
`define SVC_POINTER_CODE 4'hc
`define CLK_HZ 200000000
`define RC_OSC_HZ 28000
`define RC_OSC_CYCLES (`CLK_HZ / `RC_OSC_HZ)
`define RC_CNT_W 13
`define XTAL_DIV_BITS 4
`define MODEM_IDLE_LEVEL 1'b1
`endif

// file: hw/scsl_pkg.sv
// Types for the service-control register and serial clock selector
package scsl_pkg;
   typedef struct packed {
      logic tx_level;
      logic rx_level;
      logic tx_tick;
      logic rx_tick;
   } shift_clk_s;

   typedef struct packed {
      logic rx_clk;
      logic tx_clk;
      logic rx_data;
      logic xtal_div2;
      logic xtal_div16;
   } pin_sync_s;

   typedef struct packed {
      logic [15:0] svc;
      logic strobe_d;
      pin_sync_s s1;
      pin_sync_s s2;
      shift_clk_s clks;
      logic rx_data;
      logic modem_data;
      logic ext_clk;
   } state_s;

   typedef struct packed {
      logic [12:0] cnt;
      logic half;
   } osc_s;
endpackage

// file: hw/serial_clock_select_loopback.sv
// Service-control register, shift clock selection and loopback
`timescale 1ns/1ps
`default_nettype none
`include "scsl_consts.svh"

module serial_clock_select_loopback #(
   parameter int RC_OSC_CYCLES = `RC_OSC_CYCLES,
   parameter int XTAL_DIV_BITS = `XTAL_DIV_BITS
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic service_reg_load_strobe,
   input wire logic [15:0] bus_data,
   input wire logic tx_active,
   input wire logic half_duplex_select,
   input wire logic clock_loss_hold,
   input wire logic tx_serial_data,
   input wire logic crystal_present,
   input wire logic crystal_div16_sel,
   input wire logic modem_rx_data,
   input wire logic modem_rx_clock,
   input wire logic modem_tx_clock,
   input wire logic crystal_source_in,
   output logic [15:0] service_reg_value,
   output logic [3:0] rx_config,
   output scsl_pkg::shift_clk_s shift_clocks,
   output logic rx_serial_data,
   output logic modem_serial_out,
   output logic serial_clock_out
);
   import scsl_pkg::*;

   state_s st;
   state_s next_st;
   osc_s osc = '0;
   osc_s next_osc;

   // Crystal domain: free counter, no load and no clear
   logic [XTAL_DIV_BITS-1:0] xtal_cnt = '0;

   always_ff @(posedge crystal_source_in) begin
      xtal_cnt <= xtal_cnt + XTAL_DIV_BITS'(1);
   end

   // Oscillator needs no reset, like a power-up RC stage
   always_comb begin
      next_osc = osc;
      if (osc.cnt == 13'(RC_OSC_CYCLES - 1)) begin
         next_osc.cnt = '0;
         next_osc.half = ~osc.half;
      end else begin
         next_osc.cnt = osc.cnt + 13'h0001;
      end
   end

   always_ff @(posedge clk) begin
      osc <= next_osc;
   end

   logic load;
   logic loop_sel;
   logic rx_inhibit;
   logic stage1_rx;
   logic stage1_tx;
   logic sel_rx;
   logic sel_tx;
   logic next_rx_lvl;
   logic xtal_sel;

   assign load = service_reg_load_strobe
      & ~st.strobe_d;
   // Clock loss also flips the first stage
   assign loop_sel = st.svc[`SVC_LOOP_BIT]
      | clock_loss_hold;
   assign rx_inhibit = half_duplex_select
      & tx_active;
   assign xtal_sel = crystal_div16_sel
      ? st.s2.xtal_div16
      : st.s2.xtal_div2;

   always_comb begin
      next_st = st;
      next_st.strobe_d = service_reg_load_strobe;

      if (load) begin
         next_st.svc = bus_data
            & `SVC_HELD_MASK;
         // Bit 7 only sets with the transmitter idle
         next_st.svc[`SVC_SEND_BIT] =
            bus_data[`SVC_SEND_BIT]
            & ~tx_active;
      end

      // Pins: first stage feeds second only
      next_st.s1.rx_clk = modem_rx_clock;
      next_st.s1.tx_clk = modem_tx_clock;
      next_st.s1.rx_data = modem_rx_data;
      next_st.s1.xtal_div2 = xtal_cnt[0];
      next_st.s1.xtal_div16 =
         xtal_cnt[XTAL_DIV_BITS-1];
      next_st.s2 = st.s1;

      // First stage: modem or oscillator
      stage1_rx = loop_sel
         ? osc.half
         : st.s2.rx_clk;
      stage1_tx = loop_sel
         ? osc.half
         : st.s2.tx_clk;

      // Second stage: step mode strobe bit
      sel_rx = st.svc[`SVC_STEP_BIT]
         ? st.svc[`SVC_STROBE_BIT]
         : stage1_rx;
      sel_tx = st.svc[`SVC_STEP_BIT]
         ? st.svc[`SVC_STROBE_BIT]
         : stage1_tx;

      // Receive clock is inverted, so a strobe
      // clear gives a receive rising edge
      next_rx_lvl = rx_inhibit
         ? st.clks.rx_level
         : ~sel_rx;

      next_st.clks.tx_level = sel_tx;
      next_st.clks.rx_level = next_rx_lvl;
      next_st.clks.tx_tick = sel_tx
         & ~st.clks.tx_level;
      next_st.clks.rx_tick = next_rx_lvl
         & ~st.clks.rx_level;

      // Receiver serial input
      if (loop_sel) begin
         next_st.rx_data = tx_serial_data
            | st.svc[`SVC_SEND_BIT];
      end else begin
         next_st.rx_data = st.s2.rx_data;
      end

      // Modem line idles while looped
      next_st.modem_data = st.svc[`SVC_LOOP_BIT]
         ? `MODEM_IDLE_LEVEL
         : tx_serial_data;

      // Internal transmit clock out to modem
      next_st.ext_clk = crystal_present
         ? xtal_sel
         : osc.half;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign service_reg_value = st.svc;
   assign rx_config =
      st.svc[`SVC_CFG_MSB:`SVC_CFG_LSB];
   assign shift_clocks = st.clks;
   assign rx_serial_data = st.rx_data;
   assign modem_serial_out = st.modem_data;
   assign serial_clock_out = st.ext_clk;

   // Checks

   property p_load_bits;
      @(posedge clk) disable iff (sys_rst)
      (service_reg_load_strobe
         && !st.strobe_d)
      |=> ((st.svc & 16'h8f4b)
         == ($past(bus_data) & 16'h8f4b));
   endproperty
   a_load_bits:
      assert property (p_load_bits)
      else $error("service bits not loaded");

   property p_unheld_zero;
      @(posedge clk) disable iff (sys_rst)
      (service_reg_value & 16'h7034)
         == 16'h0000;
   endproperty
   a_unheld_zero:
      assert property (p_unheld_zero)
      else $error("unheld service bit set");

   property p_send_idle;
      @(posedge clk) disable iff (sys_rst)
      (service_reg_load_strobe
         && !st.strobe_d && tx_active)
      |=> !st.svc[`SVC_SEND_BIT];
   endproperty
   a_send_idle:
      assert property (p_send_idle)
      else $error("bit 7 set while active");

   property p_normal_data;
      @(posedge clk) disable iff (sys_rst)
      (!st.svc[`SVC_LOOP_BIT]
         && !clock_loss_hold)
      |=> rx_serial_data
         == $past(st.s2.rx_data);
   endproperty
   a_normal_data:
      assert property (p_normal_data)
      else $error("modem data not routed");

   property p_hd_inhibit;
      @(posedge clk) disable iff (sys_rst)
      (half_duplex_select && tx_active)
      |=> !shift_clocks.rx_tick;
   endproperty
   a_hd_inhibit:
      assert property (p_hd_inhibit)
      else $error("rx clock in half duplex");

   property p_loop_idle;
      @(posedge clk) disable iff (sys_rst)
      st.svc[`SVC_LOOP_BIT]
      |=> modem_serial_out == 1'b1;
   endproperty
   a_loop_idle:
      assert property (p_loop_idle)
      else $error("modem line not idle");

   property p_loop_data;
      @(posedge clk) disable iff (sys_rst)
      (st.svc[`SVC_LOOP_BIT]
         && !st.svc[`SVC_SEND_BIT])
      |=> rx_serial_data
         == $past(tx_serial_data);
   endproperty
   a_loop_data:
      assert property (p_loop_data)
      else $error("loop data not wrapped");

   property p_step_tx;
      @(posedge clk) disable iff (sys_rst)
      (st.svc[`SVC_STEP_BIT]
         && $past(st.svc[`SVC_STEP_BIT])
         && $rose(st.svc[`SVC_STROBE_BIT]))
      |=> shift_clocks.tx_tick;
   endproperty
   a_step_tx:
      assert property (p_step_tx)
      else $error("no tx step on set");

   property p_step_rx;
      @(posedge clk) disable iff (sys_rst)
      (st.svc[`SVC_STEP_BIT]
         && $past(st.svc[`SVC_STEP_BIT])
         && $fell(st.svc[`SVC_STROBE_BIT])
         && !rx_inhibit
         && !$past(rx_inhibit))
      |=> shift_clocks.rx_tick;
   endproperty
   a_step_rx:
      assert property (p_step_rx)
      else $error("no rx step on clear");

   property p_osc_period;
      @(posedge clk) disable iff (sys_rst)
      $changed(osc.half)
      |-> $past(osc.cnt)
         == 13'(RC_OSC_CYCLES - 1);
   endproperty
   a_osc_period:
      assert property (p_osc_period)
      else $error("oscillator period wrong");

   property p_step_tx_lvl;
      @(posedge clk) disable iff (sys_rst)
      st.svc[`SVC_STEP_BIT]
      |=> shift_clocks.tx_level
         == $past(st.svc[`SVC_STROBE_BIT]);
   endproperty
   a_step_tx_lvl:
      assert property (p_step_tx_lvl)
      else $error("step tx clock source");

   property p_loop_clk;
      @(posedge clk) disable iff (sys_rst)
      (st.svc[`SVC_LOOP_BIT]
         && !st.svc[`SVC_STEP_BIT])
      |=> shift_clocks.tx_level
         == $past(osc.half);
   endproperty
   a_loop_clk:
      assert property (p_loop_clk)
      else $error("loop tx clock source");

   property p_normal_tx;
      @(posedge clk) disable iff (sys_rst)
      (!loop_sel
         && !st.svc[`SVC_STEP_BIT])
      |=> shift_clocks.tx_level
         == $past(st.s2.tx_clk);
   endproperty
   a_normal_tx:
      assert property (p_normal_tx)
      else $error("modem tx clock lost");

   property p_loss_rx;
      @(posedge clk) disable iff (sys_rst)
      (clock_loss_hold
         && !st.svc[`SVC_STEP_BIT]
         && !rx_inhibit)
      |=> shift_clocks.rx_level
         == !$past(osc.half);
   endproperty
   a_loss_rx:
      assert property (p_loss_rx)
      else $error("clock loss source wrong");

   property p_cfg_load;
      @(posedge clk) disable iff (sys_rst)
      (service_reg_load_strobe && !st.strobe_d)
      |=> rx_config == $past(bus_data[`SVC_CFG_MSB:`SVC_CFG_LSB]);
   endproperty
   a_cfg_load:
      assert property (p_cfg_load)
      else $error("receiver config not loaded");

   property p_loop_rx_clk;
      @(posedge clk) disable iff (sys_rst)
      (st.svc[`SVC_LOOP_BIT] && !st.svc[`SVC_STEP_BIT] && !rx_inhibit)
      |=> shift_clocks.rx_level == !$past(osc.half);
   endproperty
   a_loop_rx_clk:
      assert property (p_loop_rx_clk)
      else $error("loop rx clock source");

   property p_normal_rx_clk;
      @(posedge clk) disable iff (sys_rst)
      (!loop_sel && !st.svc[`SVC_STEP_BIT] && !rx_inhibit)
      |=> shift_clocks.rx_level == !$past(st.s2.rx_clk);
   endproperty
   a_normal_rx_clk:
      assert property (p_normal_rx_clk)
      else $error("modem rx clock lost");

   property p_xtal16_out;
      @(posedge clk) disable iff (sys_rst)
      (crystal_present && crystal_div16_sel)
      |=> serial_clock_out == $past(st.s2.xtal_div16);
   endproperty
   a_xtal16_out:
      assert property (p_xtal16_out)
      else $error("crystal divide by 16 wrong");

   property p_xtal2_out;
      @(posedge clk) disable iff (sys_rst)
      (crystal_present && !crystal_div16_sel)
      |=> serial_clock_out == $past(st.s2.xtal_div2);
   endproperty
   a_xtal2_out:
      assert property (p_xtal2_out)
      else $error("crystal divide by 2 wrong");

   property p_rc_out;
      @(posedge clk) disable iff (sys_rst)
      !crystal_present
      |=> serial_clock_out == $past(osc.half);
   endproperty
   a_rc_out:
      assert property (p_rc_out)
      else $error("internal clock not halved oscillator");

   property p_send_level;
      @(posedge clk) disable iff (sys_rst)
      (st.svc[`SVC_LOOP_BIT] && st.svc[`SVC_SEND_BIT])
      |=> rx_serial_data;
   endproperty
   a_send_level:
      assert property (p_send_level)
      else $error("bit 7 not seen at receiver");

   property p_step_rx_lvl;
      @(posedge clk) disable iff (sys_rst)
      (st.svc[`SVC_STEP_BIT] && !rx_inhibit)
      |=> shift_clocks.rx_level == !$past(st.svc[`SVC_STROBE_BIT]);
   endproperty
   a_step_rx_lvl:
      assert property (p_step_rx_lvl)
      else $error("step rx clock source");

endmodule
`default_nettype wire

// file: dv/modem_model.sv
// Behavioural modem giving receive data and both serial clocks
`timescale 1ns/1ps
`default_nettype none
module modem_model (
   output logic rx_clock,
   output logic tx_clock,
   output logic rx_data
);
   initial begin
      rx_clock = 1'b0;
      tx_clock = 1'b0;
      rx_data = 1'b0;
   end
   // Clocks stand still between frames; released data inverts
   task automatic frame(input logic [7:0] bits, input int half_ns);
      for (int i = 0; i < 8; i++) begin
         rx_data = bits[i];
         rx_clock = 1'b0;
         tx_clock = 1'b0;
         #(half_ns);
         rx_clock = 1'b1;
         tx_clock = 1'b1;
         #(half_ns);
      end
      rx_clock = 1'b0;
      tx_clock = 1'b0;
      rx_data = ~rx_data;
   endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// Self-checking bench for the serial clock selector
`timescale 1ns/1ps
`default_nettype none
module tb;
   import scsl_pkg::*;
   logic clk = 1'b0, xtal = 1'b0, sys_rst = 1'b1, strobe = 1'b0, tx_active = 1'b0;
   logic half_dup = 1'b0, hold = 1'b0, tx_sd = 1'b0, xt_on = 1'b0, xt16 = 1'b0, sc_d = 1'b0;
   logic [15:0] bus_data = 16'h0000, model_svc = 16'h0000, lfsr = 16'hd4df;
   logic [15:0] svc_val;
   logic [3:0] rx_cfg;
   shift_clk_s sclk;
   logic rx_sd, modem_out, ser_clk, m_rxc, m_txc, m_rxd;
   logic mon_en = 1'b0;
   logic exp_q[$];
   int err_count = 0, comparisons = 0, tx_ticks = 0, rx_ticks = 0, sc_rises = 0;
   always #2.5 clk = ~clk;
   always #6 xtal = ~xtal;
   modem_model modem (.rx_clock(m_rxc), .tx_clock(m_txc), .rx_data(m_rxd));
   serial_clock_select_loopback #(.RC_OSC_CYCLES(8), .XTAL_DIV_BITS(4)) dut (.clk(clk), .sys_rst(sys_rst),
      .service_reg_load_strobe(strobe), .bus_data(bus_data), .tx_active(tx_active),
      .half_duplex_select(half_dup), .clock_loss_hold(hold), .tx_serial_data(tx_sd),
      .crystal_present(xt_on), .crystal_div16_sel(xt16), .modem_rx_data(m_rxd),
      .modem_rx_clock(m_rxc), .modem_tx_clock(m_txc), .crystal_source_in(xtal),
      .service_reg_value(svc_val), .rx_config(rx_cfg), .shift_clocks(sclk),
      .rx_serial_data(rx_sd), .modem_serial_out(modem_out), .serial_clock_out(ser_clk));
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      if (err_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic wr(input logic [15:0] d);
      @(posedge clk);
      strobe <= 1'b1;
      bus_data <= d;
      @(posedge clk);
      strobe <= 1'b0;
      model_svc = d & 16'h8fcb;
      if (tx_active) model_svc[7] = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      check(svc_val, model_svc);
      check({12'h000, rx_cfg}, {12'h000, model_svc[11:8]});
   endtask
   task automatic data_chk(input logic loop_on, input logic wrap);
      for (int i = 0; i < 6; i++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge clk);
         tx_sd <= lfsr[0];
         repeat (2) @(posedge clk);
         #1;
         check(16'(rx_sd), 16'(wrap ? tx_sd : m_rxd));
         check(16'(modem_out), 16'(loop_on ? 1'b1 : tx_sd));
      end
   endtask
   task automatic clr_cnt();
      @(posedge clk);
      #1;
      tx_ticks = 0;
      rx_ticks = 0;
      sc_rises = 0;
   endtask
   task automatic rc_count(input logic [15:0] sc_exp);
      clr_cnt();
      repeat (160) @(posedge clk);
      #1;
      check(16'(tx_ticks), 16'h000a);
      check(16'(rx_ticks), 16'h000a);
      check(16'(sc_rises), sc_exp);
   endtask
   task automatic frame_chk(input logic [15:0] rx_exp);
      lfsr = lfsr_next(lfsr);
      for (int i = 0; i < 8; i++) exp_q.push_back(lfsr[i]);
      clr_cnt();
      mon_en = 1'b1;
      modem.frame(lfsr[7:0], 40);
      repeat (10) @(posedge clk);
      mon_en = 1'b0;
      exp_q.delete();
      check(16'(tx_ticks), 16'h0008);
      check(16'(rx_ticks), rx_exp);
   endtask
   // Ticks and data are sampled from flops, so no edge race
   always @(posedge clk) begin
      if (ser_clk === 1'b1 && sc_d === 1'b0) sc_rises++;
      sc_d = ser_clk;
      if (sclk.rx_tick === 1'b1) rx_ticks++;
      if (sclk.tx_tick === 1'b1) begin
         tx_ticks++;
         if (mon_en && exp_q.size() > 0) check(16'(rx_sd), 16'(exp_q.pop_front()));
      end
   end
   initial begin
      #60000;
      err_count++;
      give_verdict();
   end
   initial begin
      repeat (7) @(posedge clk);
      #1;
      check(svc_val, 16'h0000);
      check({5'h00, rx_cfg, sclk, rx_sd, modem_out, ser_clk}, 16'h0000);
      @(posedge clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         lfsr = lfsr_next(lfsr);
         @(posedge clk);
         tx_active <= lfsr[2];
         wr(lfsr);
      end
      @(posedge clk);
      tx_active <= 1'b0;
      wr(16'h0000);
      frame_chk(16'h0008);
      data_chk(1'b0, 1'b0);
      half_dup <= 1'b1;
      tx_active <= 1'b1;
      frame_chk(16'h0000);
      half_dup <= 1'b0;
      tx_active <= 1'b0;
      hold <= 1'b1;
      data_chk(1'b0, 1'b1);
      rc_count(16'h000a);
      hold <= 1'b0;
      wr(16'h0008);
      data_chk(1'b1, 1'b1);
      rc_count(16'h000a);
      tx_sd <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         wr(i[0] ? 16'h0088 : 16'h0008);
         check(16'(rx_sd), 16'(i[0]));
      end
      // Step bit first, so only the strobe toggles make edges
      wr(16'h000a);
      clr_cnt();
      wr(16'h000b);
      check({14'h0000, sclk.tx_level, sclk.rx_level}, 16'h0002);
      wr(16'h000a);
      check({14'h0000, sclk.tx_level, sclk.rx_level}, 16'h0001);
      check(16'(tx_ticks * 4 + rx_ticks), 16'h0005);
      half_dup <= 1'b1;
      tx_active <= 1'b1;
      wr(16'h000b);
      clr_cnt();
      wr(16'h000a);
      check(16'(rx_ticks), 16'h0000);
      half_dup <= 1'b0;
      tx_active <= 1'b0;
      xt_on <= 1'b1;
      xt16 <= 1'b1;
      for (int k = 0; k < 2; k++) begin
         repeat (20) @(posedge clk);
         clr_cnt();
         repeat (384) @(posedge clk);
         check(16'(k ? (sc_rises >= 79 && sc_rises <= 81) : (sc_rises >= 9 && sc_rises <= 11)), 16'h0001);
         xt16 <= 1'b0;
      end
      // Mid-run reset must clear bits that writes have set
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      #1;
      check(svc_val, 16'h0000);
      check({11'h000, sclk, ser_clk}, 16'h0000);
      @(posedge clk);
      sys_rst <= 1'b0;
      wr(16'h0f00);
      give_verdict();
   end
endmodule
`default_nettype wire
